// ==== rtl/hub_core_pkg.sv ====
/*
 * Shared types and constants of the hub control core: LED timing, port strapping,
 * routing modes, descriptor-load limits and the grouped signal structs.
 * Assumes a 20 MHz core clock; all counts are derived from that rate.
 */
package hub_core_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned LED_DARK_MS = 100;
    localparam int unsigned LED_DARK_CYC = (CLK_HZ / 1000) * LED_DARK_MS;
    localparam int unsigned ENUM_BLINK_MS = 20;
    localparam int unsigned ENUM_BLINK_CYC = (CLK_HZ / 1000) * ENUM_BLINK_MS;
    localparam int unsigned ENUM_PERIOD_MS = 500;
    localparam int unsigned ENUM_PERIOD_CYC = (CLK_HZ / 1000) * ENUM_PERIOD_MS;
    localparam int unsigned TIMER_W = 24;

    // ************************************************************
    // Ports and buffers
    // ************************************************************
    localparam int unsigned NUM_PORTS = 4;
    localparam logic [2:0] MIN_PORTS = 3'h2;
    localparam int unsigned TT_DEPTH = 64;
    localparam int unsigned TT_AW = 6;
    localparam int unsigned DESC_MAX_BYTES = 256;
    localparam int unsigned DESC_CNT_W = 9;
    localparam logic [8:0] DESC_LIMIT = 9'h100;

    typedef enum logic [1:0] {
        ROUTE_FS_HUB = 2'h0,
        ROUTE_HS_REP = 2'h1,
        ROUTE_MINI_HOST = 2'h3
    } route_t;

    // Split-transaction translator states, Gray-coded along the usual path.
    typedef enum logic [1:0] {
        TT_IDLE = 2'h0,
        TT_FILL = 2'h1,
        TT_HOLD = 2'h3,
        TT_DRAIN = 2'h2
    } tt_state_t;

    typedef struct packed {
        logic configured;
        logic enumerating;
        logic suspended;
        logic transaction;
    } hub_status_t;

    typedef struct packed {
        logic valid;
        logic split;
        logic dir_in;
        logic last;
        logic [7:0] data;
    } tt_beat_t;

endpackage : hub_core_pkg

// ==== rtl/tt_buffer_mem.sv ====
/*
 * Translator buffer storage: single-port write, registered read.
 * Assumes the caller keeps addresses in range and sequences reads and writes.
 */
`timescale 1ns/1ps
`default_nettype none
module tt_buffer_mem (
    // Clock
    input wire logic clk,
    // Write side
    input wire logic wr_en,
    input wire logic [hub_core_pkg::TT_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Read side
    input wire logic [hub_core_pkg::TT_AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    import hub_core_pkg::*;

    logic [7:0] mem_q [TT_DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= mem_q[rd_addr];
    end
endmodule : tt_buffer_mem
`default_nettype wire

// ==== rtl/pin_sync3.sv ====
/*
 * Three-stage input synchroniser; a change is accepted when stages two and three agree.
 * Assumes the input is asynchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.out[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.out;
endmodule : pin_sync3
`default_nettype wire

// ==== rtl/usb_hub_core_control.sv ====
/*
 * Control core of a four-port hub: traffic LED, port strapping, routing selection,
 * translator buffering of split traffic, port-change reporting and descriptor-load count.
 * Assumes the packet engine and transceivers deliver decoded events on the clk domain;
 * strap pins are asynchronous and pass through three-stage synchronisers.
 */
// What the hub does; [R18] and [R19] are done by other blocks, not this one
// [R1] LED stays dark while the hub is neither configured nor enumerating.
// [R2] When configured, each host transaction darkens the LED for 100 ms.
// [R3] LED is dark whenever the hub is suspended.
// [R4] During enumeration the LED lights in short momentary pulses.
// [R5] Ports 1 and 2 are always present.
// [R6] Port 3 or 4 with both data lines strapped high is disabled.
// [R7] Board disables unused ports from port 4 downward only.
// [R8] Enabled-port count is reported in the port-count field.
// [R9] Signalling goes to mini-host, full/low repeater or high-speed repeater by topology.
// [R10] Inbound split data accumulates in buffers until required length.
// [R11] Outbound split data drains downstream paced to full/low bandwidth.
// [R12] Buffers are used only for split traffic.
// [R13] At high speed the mini-host originates all downstream full/low tokens.
// [R14] Responses are held until the matching complete-split finishes.
// [R15] Repeaters pass packet and resume signalling packet by packet.
// [R16] A full-speed upstream makes the hub a plain full/low hub.
// [R17] Any status change on an enabled port is reported on the interrupt endpoint.
// [R18] Packet engine handles sync, stuffing, CRC, PID, address, handshakes.
// [R19] Receive data is sampled with a clock recovered from the stream.
// [R20] Descriptor data loads over the two-wire bus from memory or controller.
// [R21] Descriptor transfers stop counting beyond 256 bytes.
// [R22] Reset returns unconfigured, dark LED, flushed buffers.
`timescale 1ns/1ps
`default_nettype none
module usb_hub_core_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Hub state from the packet engine
    input wire hub_core_pkg::hub_status_t hub_status,
    input wire logic upstream_high_speed,
    input wire logic downstream_low_full,
    input wire logic resume_seen,
    // Strap pins
    input wire logic [3:0] downstream_plus_line,
    input wire logic [3:0] downstream_minus_line,
    // Port status changes
    input wire logic [3:0] port_change,
    input wire logic change_report_taken,
    // Split traffic
    input wire hub_core_pkg::tt_beat_t tt_in,
    output logic tt_in_ready,
    input wire logic complete_split_done,
    input wire logic fs_slot_tick,
    input wire logic out_ready,
    output hub_core_pkg::tt_beat_t tt_out,
    input wire logic [hub_core_pkg::TT_AW-1:0] split_length,
    // Descriptor load
    input wire logic desc_byte_valid,
    input wire logic desc_xfer_start,
    output logic desc_byte_accept,
    output logic [hub_core_pkg::DESC_CNT_W-1:0] desc_count,
    // Indicators and results
    output logic traffic_led_n,
    output logic [3:0] port_enable,
    output logic [2:0] port_count_field,
    output hub_core_pkg::route_t route_sel,
    output logic mini_host_tokens,
    output logic resume_forward,
    output logic tt_collect_ready,
    output logic [4:0] change_bitmap,
    output logic change_pending
);
    import hub_core_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic led_on;
        logic [TIMER_W-1:0] dark_cnt;
        logic [TIMER_W-1:0] enum_cnt;
        logic [3:0] port_en;
        logic [2:0] port_cnt;
        route_t route;
        logic resume;
        tt_state_t tt_state;
        logic [TT_AW-1:0] wr_ptr;
        logic [TT_AW-1:0] rd_ptr;
        logic [TT_AW-1:0] fill;
        logic out_valid;
        logic out_dir_in;
        logic [4:0] changes;
        logic [DESC_CNT_W-1:0] desc_cnt;
    } core_state_t;

    core_state_t st_q;
    core_state_t st_d;

    logic [3:0] dp_sync;
    logic [3:0] dm_sync;
    logic [7:0] mem_rd_data;
    logic mem_wr;
    logic [TT_AW-1:0] mem_rd_addr;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [2:0] count_ports(input logic [3:0] en);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            n = n + {2'h0, en[i]};
        end
        return n;
    endfunction : count_ports

    function automatic logic [TIMER_W-1:0] dec_sat(input logic [TIMER_W-1:0] v);
        return (v == '0) ? '0 : v - {{(TIMER_W-1){1'b0}}, 1'b1};
    endfunction : dec_sat

    // ************************************************************
    // Strap synchronisers
    // ************************************************************
    pin_sync3 #(
        .W(4)
    ) u_sync_dp (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(downstream_plus_line),
        .sync_out(dp_sync)
    );

    pin_sync3 #(
        .W(4)
    ) u_sync_dm (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(downstream_minus_line),
        .sync_out(dm_sync)
    );

    // ************************************************************
    // Translator buffer
    // ************************************************************
    assign mem_wr = tt_in.valid && tt_in.split && tt_in_ready;
    // While a byte stands on the output, re-read its own address so the data holds.
    assign mem_rd_addr = st_q.out_valid ? (st_q.rd_ptr - 1'b1) : st_q.rd_ptr;

    tt_buffer_mem u_tt_mem (
        .clk(clk),
        .wr_en(mem_wr),
        .wr_addr(st_q.wr_ptr),
        .wr_data(tt_in.data),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [3:0] strap_en;
        logic drain_fire;
        strap_en = 4'h0;
        drain_fire = 1'b0;
        st_d = st_q;

        // Traffic indicator. Suspend overrides everything, unconfigured and not enumerating keeps it dark.
        st_d.dark_cnt = dec_sat(st_q.dark_cnt);
        st_d.enum_cnt = dec_sat(st_q.enum_cnt);
        if (hub_status.suspended) begin
            st_d.led_on = 1'b0; // [R3]
            st_d.dark_cnt = '0;
        end else if (hub_status.configured) begin
            if (hub_status.transaction) begin
                st_d.dark_cnt = TIMER_W'(LED_DARK_CYC); // [R2]
            end
            st_d.led_on = (st_d.dark_cnt == '0); // [R2]
        end else if (hub_status.enumerating) begin
            if (st_q.enum_cnt == '0) begin
                st_d.enum_cnt = TIMER_W'(ENUM_PERIOD_CYC);
            end
            // Lit only during the first short slice of each period.
            st_d.led_on = (st_d.enum_cnt > TIMER_W'(ENUM_PERIOD_CYC - ENUM_BLINK_CYC)); // [R4]
        end else begin
            st_d.led_on = 1'b0; // [R1]
            st_d.enum_cnt = '0;
        end

        // Port strapping: ports 1 and 2 cannot be removed.
        for (int i = 0; i < NUM_PORTS; i++) begin
            strap_en[i] = !(dp_sync[i] && dm_sync[i]); // [R6]
        end
        strap_en[1:0] = 2'h3; // [R5]
        // A gap in the strapping truncates at the first disabled port.
        if (!strap_en[2]) begin
            strap_en[3] = 1'b0; // [R7]
        end
        st_d.port_en = strap_en;
        st_d.port_cnt = count_ports(strap_en); // [R8]

        // Routing by upstream topology.
        if (!upstream_high_speed) begin
            st_d.route = ROUTE_FS_HUB; // [R16]
        end else if (downstream_low_full) begin
            st_d.route = ROUTE_MINI_HOST; // [R9] [R13]
        end else begin
            st_d.route = ROUTE_HS_REP; // [R9]
        end
        st_d.resume = resume_seen; // [R15]

        // Port status change bitmap, bit 0 is the hub itself. Set wins over clear.
        if (change_report_taken) begin
            st_d.changes = 5'h0;
        end
        st_d.changes[4:1] = st_d.changes[4:1] | (port_change & st_q.port_en); // [R17]

        // Translator: split beats fill, others bypass.
        drain_fire = st_q.out_valid && out_ready;
        if (drain_fire) begin
            st_d.out_valid = 1'b0;
        end
        case (st_q.tt_state)
            TT_IDLE: begin
                st_d.wr_ptr = '0;
                st_d.rd_ptr = '0;
                st_d.fill = '0;
                if (mem_wr) begin
                    st_d.wr_ptr = st_q.wr_ptr + 1'b1;
                    st_d.fill = st_q.fill + 1'b1;
                    st_d.out_dir_in = tt_in.dir_in;
                    st_d.tt_state = TT_FILL;
                end
            end
            TT_FILL: begin
                if (mem_wr) begin
                    st_d.wr_ptr = st_q.wr_ptr + 1'b1;
                    st_d.fill = st_q.fill + 1'b1; // [R10]
                end
                if (mem_wr && (tt_in.last || st_d.fill >= split_length)) begin
                    st_d.tt_state = st_q.out_dir_in ? TT_HOLD : TT_DRAIN; // [R10]
                end
            end
            TT_HOLD: begin
                // Held until the complete-split ends, then released.
                if (complete_split_done) begin
                    st_d.tt_state = TT_DRAIN; // [R14]
                end
            end
            TT_DRAIN: begin
                // One byte per full/low slot until the buffer is empty.
                if (fs_slot_tick && !st_d.out_valid && st_q.rd_ptr != st_q.wr_ptr) begin
                    st_d.out_valid = 1'b1; // [R11]
                    st_d.rd_ptr = st_q.rd_ptr + 1'b1;
                end
                if (st_q.rd_ptr == st_q.wr_ptr && !st_q.out_valid) begin
                    st_d.tt_state = TT_IDLE; // [R11] [R14]
                    // Flushed here so a split beat in the very next cycle starts at zero.
                    st_d.wr_ptr = '0;
                    st_d.rd_ptr = '0;
                    st_d.fill = '0;
                end
            end
            default: begin
                st_d.tt_state = TT_IDLE;
            end
        endcase

        // Descriptor load byte count, saturating at the limit.
        if (desc_xfer_start) begin
            st_d.desc_cnt = '0;
        end else if (desc_byte_valid && st_q.desc_cnt < DESC_LIMIT) begin
            st_d.desc_cnt = st_q.desc_cnt + 1'b1; // [R20] [R21]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0; // [R22]
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Buffer accepts split beats only when idle or filling; non-split traffic never waits.
    assign tt_in_ready = !tt_in.split ||
        (st_q.tt_state == TT_IDLE) || (st_q.tt_state == TT_FILL); // [R12]
    assign tt_out = '{valid: st_q.out_valid, split: 1'b1, dir_in: st_q.out_dir_in,
        last: (st_q.rd_ptr == st_q.wr_ptr), data: mem_rd_data};
    assign tt_collect_ready = (st_q.tt_state == TT_HOLD); // [R10]
    assign traffic_led_n = !st_q.led_on;
    assign port_enable = st_q.port_en;
    assign port_count_field = (st_q.port_cnt < MIN_PORTS) ? MIN_PORTS : st_q.port_cnt;
    assign route_sel = st_q.route;
    assign mini_host_tokens = (st_q.route == ROUTE_MINI_HOST); // [R13]
    assign resume_forward = st_q.resume && (st_q.route != ROUTE_MINI_HOST); // [R15]
    assign change_bitmap = st_q.changes;
    assign change_pending = |st_q.changes; // [R17]
    assign desc_byte_accept = desc_byte_valid && (st_q.desc_cnt < DESC_LIMIT); // [R21]
    assign desc_count = st_q.desc_cnt;

endmodule : usb_hub_core_control
`default_nettype wire

// ==== tb/hub_core_sva.sv ====
/*
 * Port checker of the hub control core: LED, straps, routing, change report, descriptor count.
 * Assumes it is bound to usb_hub_core_control and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module hub_core_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Inputs
    input wire hub_core_pkg::hub_status_t hub_status,
    input wire logic upstream_high_speed,
    input wire logic downstream_low_full,
    input wire logic [3:0] downstream_plus_line,
    input wire logic [3:0] downstream_minus_line,
    input wire logic [3:0] port_change,
    input wire logic desc_byte_valid,
    input wire logic desc_xfer_start,
    // Outputs
    input wire logic desc_byte_accept,
    input wire logic [hub_core_pkg::DESC_CNT_W-1:0] desc_count,
    input wire logic traffic_led_n,
    input wire logic [3:0] port_enable,
    input wire logic [2:0] port_count_field,
    input wire hub_core_pkg::route_t route_sel,
    input wire logic mini_host_tokens,
    input wire logic [4:0] change_bitmap,
    input wire logic change_pending
);
    import hub_core_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // The dark interval is far too long for a repetition, so a counter tracks it.
    logic [23:0] dark_q, dark_d;
    always_comb begin
        dark_d = dark_q;
        if (hub_status.configured && hub_status.transaction) begin
            dark_d = 24'(LED_DARK_CYC);
        end else if (dark_q != 24'h0) begin
            dark_d = dark_q - 24'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dark_q <= 24'h0;
        end else begin
            dark_q <= dark_d;
        end
    end
    sequence s_strap_off(int i);
        (downstream_plus_line[i] && downstream_minus_line[i])[*6];
    endsequence
    a_led_unconfig: assert property (!hub_status.configured && !hub_status.enumerating |=> traffic_led_n) else $error("led lit before configuration");
    a_led_suspend: assert property (hub_status.suspended |=> traffic_led_n) else $error("led lit in suspend");
    a_led_blink: assert property (hub_status.configured && hub_status.transaction |=> traffic_led_n) else $error("led not darkened by transaction");
    a_led_hold: assert property (dark_q > 24'h1 |-> traffic_led_n) else $error("dark interval cut short");
    a_ports_fixed: assert property (rst_n[*6] |-> port_enable[1:0] == 2'h3) else $error("port 1 or 2 missing");
    a_port4_off: assert property (s_strap_off(3) |-> !port_enable[3]) else $error("strapped port 4 enabled");
    a_port3_off: assert property (s_strap_off(2) |-> port_enable[3:2] == 2'h0) else $error("strapped port 3 enabled");
    a_count_field: assert property (port_enable[0] |-> port_count_field == 3'($countones(port_enable))) else $error("port count wrong");
    a_route_fs: assert property (!upstream_high_speed |=> route_sel == ROUTE_FS_HUB) else $error("full speed route wrong");
    a_route_hs: assert property (upstream_high_speed && !downstream_low_full |=> route_sel == ROUTE_HS_REP) else $error("high speed route wrong");
    a_mini_host: assert property (upstream_high_speed && downstream_low_full |=> route_sel == ROUTE_MINI_HOST && mini_host_tokens) else $error("mini host not chosen");
    a_change_seen: assert property (port_change != 4'h0 |=> change_pending && (change_bitmap[4:1] & $past(port_change)) == $past(port_change)) else $error("change not reported");
    a_desc_limit: assert property (desc_count <= DESC_LIMIT) else $error("descriptor count beyond limit");
    a_desc_refuse: assert property (desc_byte_valid && !desc_xfer_start && desc_count == DESC_LIMIT |-> !desc_byte_accept) else $error("byte accepted past limit");
endmodule : hub_core_sva
bind usb_hub_core_control hub_core_sva u_sva (.clk, .rst_n, .hub_status, .upstream_high_speed,
    .downstream_low_full, .downstream_plus_line, .downstream_minus_line, .port_change,
    .desc_byte_valid, .desc_xfer_start, .desc_byte_accept, .desc_count, .traffic_led_n,
    .port_enable, .port_count_field, .route_sel, .mini_host_tokens, .change_bitmap,
    .change_pending);
`default_nettype wire

// ==== tb/upstream_host_model.sv ====
/*
 * Behavioural upstream host: drives the hub state seen by the core.
 * Assumes the bench calls its tasks; every change lands on a falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module upstream_host_model (
    // Clock
    input wire logic clk,
    // Hub state as the host leaves it
    output var hub_core_pkg::hub_status_t hub_status,
    output var logic upstream_high_speed
);
    import hub_core_pkg::*;
    initial begin
        hub_status = '0;
        upstream_high_speed = 1'b1;
    end
    task automatic set_state(input logic cfg, input logic susp);
        @(negedge clk);
        hub_status.configured = cfg;
        hub_status.suspended = susp;
    endtask : set_state
    // A transaction is one clock long, as the packet engine reports it.
    task automatic xact();
        @(negedge clk);
        hub_status.transaction = 1'b1;
        @(negedge clk);
        hub_status.transaction = 1'b0;
    endtask : xact
    task automatic set_speed(input logic hs);
        @(negedge clk);
        upstream_high_speed = hs;
    endtask : set_speed
endmodule : upstream_host_model
`default_nettype wire

// ==== tb/usb_hub_core_control_test.sv ====
/*
 * Self-checking bench of the hub control core with an upstream host model.
 * Assumes the checker is bound by its own file; inputs move on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module usb_hub_core_control_test;
    import hub_core_pkg::*;
    logic clk, rst_n, downstream_low_full, resume_seen, change_report_taken;
    logic complete_split_done, fs_slot_tick, out_ready, desc_byte_valid, desc_xfer_start;
    logic [3:0] downstream_plus_line, downstream_minus_line, port_change, port_enable;
    logic tt_in_ready, desc_byte_accept, traffic_led_n, mini_host_tokens, resume_forward;
    logic tt_collect_ready, change_pending;
    logic [TT_AW-1:0] split_length;
    logic [DESC_CNT_W-1:0] desc_count;
    logic [2:0] port_count_field;
    logic [4:0] change_bitmap;
    tt_beat_t tt_in, tt_out;
    route_t route_sel;
    wire hub_status_t hub_status;
    wire logic upstream_high_speed;
    int error_cnt = 0, checks = 0, cyc = 0;
    upstream_host_model u_host (.clk, .hub_status, .upstream_high_speed);
    usb_hub_core_control u_dut (.clk, .rst_n, .hub_status, .upstream_high_speed,
        .downstream_low_full, .resume_seen, .downstream_plus_line, .downstream_minus_line,
        .port_change, .change_report_taken, .tt_in, .tt_in_ready, .complete_split_done,
        .fs_slot_tick, .out_ready, .tt_out, .split_length, .desc_byte_valid, .desc_xfer_start,
        .desc_byte_accept, .desc_count, .traffic_led_n, .port_enable, .port_count_field,
        .route_sel, .mini_host_tokens, .resume_forward, .tt_collect_ready, .change_bitmap,
        .change_pending);
    always #25 clk = ~clk;
    // The whole run needs some 1,400 cycles; the ceiling leaves ample margin.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
    endtask : do_reset
    task automatic send_beat(input tt_beat_t b);
        int n;
        tt_in = b;
        n = 0;
        #1;
        while (tt_in_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            #1;
            n++;
        end
        check(tt_in_ready, 1'b1);
        @(negedge clk);
    endtask : send_beat
    task automatic drain_byte(input logic [7:0] exp);
        int n;
        fs_slot_tick = 1'b1;
        @(negedge clk);
        fs_slot_tick = 1'b0;
        n = 0;
        while (tt_out.valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check(tt_out.data, exp);
        out_ready = 1'b1;
        @(negedge clk);
        out_ready = 1'b0;
    endtask : drain_byte
    task automatic t_led();
        u_host.set_state(1'b1, 1'b0);
        repeat (2) @(negedge clk);
        check(traffic_led_n, 1'b0);
        u_host.set_state(1'b1, 1'b1);
        repeat (2) @(negedge clk);
        check(traffic_led_n, 1'b1);
        u_host.set_state(1'b1, 1'b0);
        repeat (2) @(negedge clk);
        rst_n = 1'b0;
        #1;
        check(traffic_led_n, 1'b1);
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        u_host.xact();
        repeat (1000) @(negedge clk);
        check(traffic_led_n, 1'b1);
    endtask : t_led
    task automatic t_strap();
        for (int n = 4; n >= 1; n--) begin
            downstream_plus_line = (n == 1) ? 4'h1 : 4'(4'hf << n);
            downstream_minus_line = downstream_plus_line;
            repeat (6) @(negedge clk);
            check(port_enable, (n == 1) ? 4'hf : 4'(4'hf >> (4 - n)));
            check(port_count_field, (n == 1) ? 3'h4 : 3'(n));
        end
        downstream_plus_line = 4'h8;
        downstream_minus_line = 4'h0;
        repeat (6) @(negedge clk);
        check(port_enable, 4'hf);
    endtask : t_strap
    task automatic t_route();
        for (int i = 0; i < 4; i++) begin
            u_host.set_speed(i[1]);
            downstream_low_full = i[0];
            repeat (2) @(negedge clk);
            check(route_sel, !i[1] ? ROUTE_FS_HUB : i[0] ? ROUTE_MINI_HOST : ROUTE_HS_REP);
        end
        u_host.set_speed(1'b0);
        resume_seen = 1'b1;
        @(negedge clk);
        resume_seen = 1'b0;
        check(resume_forward, 1'b1);
    endtask : t_route
    task automatic t_change();
        port_change = 4'h5;
        @(negedge clk);
        port_change = 4'h0;
        check({change_pending, change_bitmap}, 6'h2a);
        change_report_taken = 1'b1;
        @(negedge clk);
        change_report_taken = 1'b0;
        check({change_pending, change_bitmap}, 6'h00);
    endtask : t_change
    task automatic t_desc();
        desc_xfer_start = 1'b1;
        @(negedge clk);
        desc_xfer_start = 1'b0;
        desc_byte_valid = 1'b1;
        #1;
        check(desc_byte_accept, 1'b1);
        repeat (260) @(negedge clk);
        check(desc_byte_accept, 1'b0);
        desc_byte_valid = 1'b0;
        @(negedge clk);
        check(desc_count, 9'h100);
    endtask : t_desc
    task automatic t_split();
        split_length = 6'h4;
        for (int i = 0; i < 4; i++) send_beat({3'h7, i == 3, 8'ha0 + 8'(i)});
        tt_in = {4'he, 8'h55};
        @(negedge clk);
        check({tt_collect_ready, tt_in_ready}, 2'h2);
        tt_in = '0;
        fs_slot_tick = 1'b1;
        @(negedge clk);
        fs_slot_tick = 1'b0;
        repeat (2) @(negedge clk);
        check(tt_out.valid, 1'b0);
        complete_split_done = 1'b1;
        @(negedge clk);
        complete_split_done = 1'b0;
        for (int i = 0; i < 4; i++) drain_byte(8'ha0 + 8'(i));
        tt_in = {4'h9, 8'h77};
        @(negedge clk);
        tt_in = '0;
        repeat (4) @(negedge clk);
        check(tt_out.valid, 1'b0);
        for (int i = 0; i < 3; i++) send_beat({3'h6, i == 2, 8'h10 + 8'(i)});
        tt_in = '0;
        repeat (3) @(negedge clk);
        check(tt_out.valid, 1'b0);
        for (int i = 0; i < 3; i++) drain_byte(8'h10 + 8'(i));
    endtask : t_split
    initial begin
        clk = 1'b0;
        {downstream_low_full, resume_seen, change_report_taken, complete_split_done} = '0;
        {fs_slot_tick, out_ready, desc_byte_valid, desc_xfer_start} = '0;
        {downstream_plus_line, downstream_minus_line, port_change} = '0;
        split_length = '0;
        tt_in = '0;
        do_reset();
        repeat (2) @(negedge clk);
        check(traffic_led_n, 1'b1);
        t_led();
        t_strap();
        t_route();
        t_change();
        t_desc();
        t_split();
        stop_test();
    end
endmodule : usb_hub_core_control_test
`default_nettype wire
